// File: design/lcr_pkg.sv
// Shared constants, types and helpers for the line control register bank
package lcr_pkg;

  // Register map
  localparam logic [7:0] LCR_TX_CFG_ADDR = 8'h04;
  localparam logic [7:0] LCR_RX_CFG_ADDR = 8'h05;
  localparam logic [7:0] LCR_TX_CFG_RESET = 8'h00;
  localparam logic [7:0] LCR_RX_CFG_RESET = 8'h00;
  localparam logic [7:0] LCR_UNMAPPED_READ = 8'h00;

  // Transmit configuration fields
  localparam int LCR_TX_BYPASS_BIT = 0;
  localparam int LCR_TX_EDGE_BIT = 1;
  localparam int LCR_TX_MARKS_BIT = 2;
  localparam int LCR_TX_UNUSED_BIT = 3;
  localparam int LCR_TX_ERR_BIT = 4;
  localparam int LCR_TX_MON_BIT = 5;
  // Bits that hold a value; the error bit is a write-only strobe
  localparam logic [7:0] LCR_TX_STORE_MASK = 8'h27;

  // Receive configuration fields
  localparam int LCR_RX_EQ_BIT = 0;
  localparam int LCR_RX_MON_BIT = 1;
  localparam int LCR_RX_MUTE_BIT = 2;
  localparam int LCR_RX_EDGE_BIT = 3;
  localparam int LCR_RX_ANALOG_SIGNAL_LOSS_OFF_BIT = 4;
  localparam int LCR_RX_DIGITAL_SIGNAL_LOSS_OFF_BIT = 5;
  localparam logic [7:0] LCR_RX_STORE_MASK = 8'h3F;

  // Driver monitor: silent bit periods before a failure is flagged
  localparam logic [7:0] LCR_MON_SILENT_LIMIT = 8'h80;

  typedef enum logic [1:0] {
    LCR_MON_IDLE = 2'b00,
    LCR_MON_WATCH = 2'b01,
    LCR_MON_FAIL = 2'b11
  } lcr_mon_state_t;

  // Edge of a sampled line clock, rising or falling as selected
  function automatic logic lcr_edge(input logic now_lvl,
                                    input logic prev_lvl,
                                    input logic rising);
    return rising ? (now_lvl & ~prev_lvl) : (~now_lvl & prev_lvl);
  endfunction : lcr_edge

endpackage : lcr_pkg

// File: design/lcr_cfg_if.sv
// Configuration and status carrier between the register bank and data paths
`timescale 1ns/1ps
`default_nettype none
interface lcr_cfg_if;
  logic build_out_bypass;
  logic tx_sample_rise;
  logic send_all_marks;
  logic line_tip;
  logic line_ring;
  logic bit_tick;
  logic mute_active;
  logic rx_output_fall;
  logic rx_pos;
  logic rx_neg;

  modport ctl (output build_out_bypass, output tx_sample_rise,
               output send_all_marks, output mute_active,
               output rx_output_fall, input line_tip, input line_ring,
               input bit_tick, input rx_pos, input rx_neg);
  modport tx (input build_out_bypass, input tx_sample_rise,
              input send_all_marks, output line_tip, output line_ring,
              output bit_tick);
  modport rx (input mute_active, input rx_output_fall,
              output rx_pos, output rx_neg);
endinterface : lcr_cfg_if
`default_nettype wire

// File: design/lcr_tx_path.sv
// Transmit data capture on the selected clock edge, with all-marks override
`timescale 1ns/1ps
`default_nettype none
module lcr_tx_path
  import lcr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Line side
  input wire logic i_clk_pin,
  input wire logic i_pos,
  input wire logic i_neg,
  // Carrier
  lcr_cfg_if.tx cfg
);

  logic clk_prev_reg;
  logic tick;
  logic tip_reg;
  logic ring_reg;
  logic tick_reg;
  logic mark_phase_reg;

  // Previous level only; defined one cycle after any reset
  always_ff @(posedge i_clk) begin
    clk_prev_reg <= i_clk_pin;
  end

  assign tick = lcr_edge(i_clk_pin, clk_prev_reg,
                         cfg.tx_sample_rise);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick;
    end
  end

  // Marks alternate polarity so the line stays balanced
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tip_reg <= 1'b0;
      ring_reg <= 1'b0;
      mark_phase_reg <= 1'b0;
    end else if (tick) begin
      if (cfg.send_all_marks) begin
        tip_reg <= ~mark_phase_reg;
        ring_reg <= mark_phase_reg;
        mark_phase_reg <= ~mark_phase_reg;
      end else begin
        tip_reg <= i_pos;
        ring_reg <= i_neg;
      end
    end
  end

  assign cfg.line_tip = tip_reg;
  assign cfg.line_ring = ring_reg;
  assign cfg.bit_tick = tick_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_TX_MARK: assert property (
    tick && cfg.send_all_marks |=> (tip_reg ^ ring_reg))
    else $error("all-marks mode did not send a mark");
  AST_TX_EDGE: assert property (
    tick_reg && $past(cfg.tx_sample_rise) && $past(cfg.tx_sample_rise, 2)
    |-> $past(i_clk_pin) && !$past(i_clk_pin, 2))
    else $error("transmit data taken off the rising edge");

endmodule : lcr_tx_path
`default_nettype wire

// File: design/lcr_rx_path.sv
// Recovered data output on the selected clock edge, with mute on signal loss
`timescale 1ns/1ps
`default_nettype none
module lcr_rx_path
  import lcr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Recovered data in
  input wire logic i_clk_pin,
  input wire logic i_pos,
  input wire logic i_neg,
  // Carrier
  lcr_cfg_if.rx cfg
);

  logic clk_prev_reg;
  logic out_edge;
  logic pos_reg;
  logic neg_reg;

  always_ff @(posedge i_clk) begin
    clk_prev_reg <= i_clk_pin;
  end

  assign out_edge = lcr_edge(i_clk_pin, clk_prev_reg,
                             ~cfg.rx_output_fall);

  // Mute wins over the edge so no stale bit leaks during loss
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
    end else if (cfg.mute_active) begin
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
    end else if (out_edge) begin
      pos_reg <= i_pos;
      neg_reg <= i_neg;
    end
  end

  assign cfg.rx_pos = pos_reg;
  assign cfg.rx_neg = neg_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_fall_seen;
    cfg.rx_output_fall && !cfg.mute_active && clk_prev_reg && !i_clk_pin;
  endsequence
  AST_RX_FALL: assert property (
    s_fall_seen |=> pos_reg == $past(i_pos) && neg_reg == $past(i_neg))
    else $error("recovered data not updated on falling edge");
  AST_RX_MUTE: assert property (
    cfg.mute_active |=> !pos_reg && !neg_reg)
    else $error("recovered data not muted during loss");

endmodule : lcr_rx_path
`default_nettype wire

// File: design/lcr_line_ctrl.sv
// Line configuration registers and the paths they control
`timescale 1ns/1ps
`default_nettype none
module lcr_line_ctrl
  import lcr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic i_reg_wr_en,
  input wire logic i_reg_rd_en,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rdata_valid,
  // Transmit side
  input wire logic i_transmit_clock_pin,
  input wire logic i_transmit_positive_data,
  input wire logic i_transmit_negative_data,
  input wire logic i_prbs_enable,
  output logic o_line_out_tip,
  output logic o_line_out_ring,
  output logic o_build_out_bypass,
  output logic o_test_error_insert,
  // Driver monitor
  input wire logic i_monitor_in_tip,
  input wire logic i_monitor_in_ring,
  output logic o_driver_failure_output,
  // Receive side
  input wire logic i_recovered_clock_pin,
  input wire logic i_rx_positive_data,
  input wire logic i_rx_negative_data,
  input wire logic i_analog_loss_raw,
  input wire logic i_digital_loss_raw,
  output logic o_recovered_positive_data,
  output logic o_recovered_negative_data,
  output logic o_equalizer_on,
  output logic o_receive_monitor_mode,
  output logic o_analog_signal_loss,
  output logic o_digital_signal_loss
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] tx_cfg_reg;
  logic [7:0] rx_cfg_reg;
  logic [7:0] rdata_reg;
  logic rdata_valid_reg;
  logic err_insert_reg;
  logic analog_signal_loss_reg;
  logic digital_signal_loss_reg;
  logic mute_reg;
  logic fail_reg;
  logic [7:0] silent_cnt_reg;
  logic [7:0] silent_cnt_next;
  lcr_mon_state_t mon_state_reg;
  lcr_mon_state_t mon_state_next;
  logic wr_tx;
  logic wr_rx;
  logic mon_pulse;
  logic analog_signal_loss_next;
  logic digital_signal_loss_next;

  lcr_cfg_if cfg ();

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  ////////////////////////////////////////////////////////////////////////////

  assign wr_tx = i_reg_wr_en && (i_reg_addr == LCR_TX_CFG_ADDR);
  assign wr_rx = i_reg_wr_en && (i_reg_addr == LCR_RX_CFG_ADDR);

  // Unused and strobe bits are masked so they never store
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tx_cfg_reg <= LCR_TX_CFG_RESET;
    end else if (wr_tx) begin
      tx_cfg_reg <= i_reg_wdata & LCR_TX_STORE_MASK;
    end
  end

  // Only a write changes this register; loss ending leaves it alone
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rx_cfg_reg <= LCR_RX_CFG_RESET;
    end else if (wr_rx) begin
      rx_cfg_reg <= i_reg_wdata & LCR_RX_STORE_MASK;
    end
  end

  // One-cycle request to the sequence generator; dropped when it is off
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      err_insert_reg <= 1'b0;
    end else begin
      err_insert_reg <= wr_tx && i_reg_wdata[LCR_TX_ERR_BIT]
                        && i_prbs_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads
  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rdata_reg <= LCR_UNMAPPED_READ;
      rdata_valid_reg <= 1'b0;
    end else begin
      rdata_valid_reg <= i_reg_rd_en;
      if (i_reg_rd_en) begin
        unique case (i_reg_addr)
          LCR_TX_CFG_ADDR: begin
            rdata_reg <= tx_cfg_reg;
          end
          LCR_RX_CFG_ADDR: begin
            rdata_reg <= rx_cfg_reg;
          end
          default: begin
            rdata_reg <= LCR_UNMAPPED_READ;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loss of signal and mute
  ////////////////////////////////////////////////////////////////////////////

  assign analog_signal_loss_next = i_analog_loss_raw &&
                     !rx_cfg_reg[LCR_RX_ANALOG_SIGNAL_LOSS_OFF_BIT];
  assign digital_signal_loss_next = i_digital_loss_raw &&
                     !rx_cfg_reg[LCR_RX_DIGITAL_SIGNAL_LOSS_OFF_BIT];

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      analog_signal_loss_reg <= 1'b0;
      digital_signal_loss_reg <= 1'b0;
    end else begin
      analog_signal_loss_reg <= analog_signal_loss_next;
      digital_signal_loss_reg <= digital_signal_loss_next;
    end
  end

  // Mute follows the declared loss in the same cycle, when the mute bit is set
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      mute_reg <= 1'b0;
    end else begin
      mute_reg <= rx_cfg_reg[LCR_RX_MUTE_BIT] &&
                  (analog_signal_loss_next || digital_signal_loss_next);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver monitor
  ////////////////////////////////////////////////////////////////////////////

  // Source select: own driver outputs or the external monitor pins
  assign mon_pulse = tx_cfg_reg[LCR_TX_MON_BIT] ?
                     (cfg.line_tip || cfg.line_ring) :
                     (i_monitor_in_tip || i_monitor_in_ring);

  // Counts transmit bit periods with no pulse seen on the chosen source
  always_comb begin
    mon_state_next = mon_state_reg;
    silent_cnt_next = silent_cnt_reg;
    unique case (mon_state_reg)
      LCR_MON_IDLE: begin
        silent_cnt_next = 8'h00;
        if (cfg.bit_tick) begin
          mon_state_next = LCR_MON_WATCH;
        end
      end
      LCR_MON_WATCH: begin
        if (mon_pulse) begin
          silent_cnt_next = 8'h00;
        end else if (cfg.bit_tick) begin
          silent_cnt_next = silent_cnt_reg + 8'h01;
          if (silent_cnt_next == LCR_MON_SILENT_LIMIT) begin
            mon_state_next = LCR_MON_FAIL;
          end
        end
      end
      LCR_MON_FAIL: begin
        if (mon_pulse) begin
          silent_cnt_next = 8'h00;
          mon_state_next = LCR_MON_WATCH;
        end
      end
      default: begin
        silent_cnt_next = 8'h00;
        mon_state_next = LCR_MON_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      mon_state_reg <= LCR_MON_IDLE;
      silent_cnt_reg <= 8'h00;
    end else begin
      mon_state_reg <= mon_state_next;
      silent_cnt_reg <= silent_cnt_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      fail_reg <= 1'b0;
    end else begin
      fail_reg <= (mon_state_next == LCR_MON_FAIL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data paths
  ////////////////////////////////////////////////////////////////////////////

  assign cfg.build_out_bypass = tx_cfg_reg[LCR_TX_BYPASS_BIT];
  assign cfg.tx_sample_rise = tx_cfg_reg[LCR_TX_EDGE_BIT];
  assign cfg.send_all_marks = tx_cfg_reg[LCR_TX_MARKS_BIT];
  assign cfg.mute_active = mute_reg;
  assign cfg.rx_output_fall = rx_cfg_reg[LCR_RX_EDGE_BIT];

  lcr_tx_path u_tx (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_clk_pin(i_transmit_clock_pin),
    .i_pos(i_transmit_positive_data),
    .i_neg(i_transmit_negative_data),
    .cfg(cfg.tx)
  );

  lcr_rx_path u_rx (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_clk_pin(i_recovered_clock_pin),
    .i_pos(i_rx_positive_data),
    .i_neg(i_rx_negative_data),
    .cfg(cfg.rx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  ////////////////////////////////////////////////////////////////////////////

  assign o_reg_rdata = rdata_reg;
  assign o_reg_rdata_valid = rdata_valid_reg;
  assign o_line_out_tip = cfg.line_tip;
  assign o_line_out_ring = cfg.line_ring;
  assign o_build_out_bypass = cfg.build_out_bypass;
  assign o_test_error_insert = err_insert_reg;
  assign o_driver_failure_output = fail_reg;
  assign o_recovered_positive_data = cfg.rx_pos;
  assign o_recovered_negative_data = cfg.rx_neg;
  assign o_equalizer_on = rx_cfg_reg[LCR_RX_EQ_BIT];
  assign o_receive_monitor_mode = rx_cfg_reg[LCR_RX_MON_BIT];
  assign o_analog_signal_loss = analog_signal_loss_reg;
  assign o_digital_signal_loss = digital_signal_loss_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_TX_BYPASS: assert property (
    wr_tx |=> o_build_out_bypass == $past(i_reg_wdata[LCR_TX_BYPASS_BIT]))
    else $error("build-out bypass does not follow write");
  AST_TX_UNUSED: assert property (
    wr_tx |=> tx_cfg_reg[LCR_TX_UNUSED_BIT] == 1'b0)
    else $error("unused transmit bit stored a value");
  AST_ERR_SINGLE: assert property (
    o_test_error_insert |=> !o_test_error_insert)
    else $error("error insertion lasted more than one cycle");
  AST_ERR_GATED: assert property (
    o_test_error_insert |-> $past(i_prbs_enable) && $past(wr_tx))
    else $error("error inserted without generator enabled");
  AST_EQ_ON: assert property (
    wr_rx ##1 !wr_rx |->
    o_equalizer_on == $past(i_reg_wdata[LCR_RX_EQ_BIT]))
    else $error("equalizer enable does not follow write");
  AST_RX_MONMODE: assert property (
    wr_rx |=> o_receive_monitor_mode == $past(i_reg_wdata[LCR_RX_MON_BIT]))
    else $error("monitor mode does not follow write");
  AST_MUTE_HOLD: assert property (
    !wr_rx |=> $stable(rx_cfg_reg[LCR_RX_MUTE_BIT]))
    else $error("mute bit changed without a write");
  AST_ANALOG_SIGNAL_LOSS_OFF: assert property (
    rx_cfg_reg[LCR_RX_ANALOG_SIGNAL_LOSS_OFF_BIT] |=> !o_analog_signal_loss)
    else $error("analog loss reported while disabled");
  AST_DIGITAL_SIGNAL_LOSS_OFF: assert property (
    rx_cfg_reg[LCR_RX_DIGITAL_SIGNAL_LOSS_OFF_BIT] |=> !o_digital_signal_loss)
    else $error("digital loss reported while disabled");
  AST_MUTE_PATH: assert property (
    rx_cfg_reg[LCR_RX_MUTE_BIT] && i_analog_loss_raw &&
    !rx_cfg_reg[LCR_RX_ANALOG_SIGNAL_LOSS_OFF_BIT] && !wr_rx
    |=> ##1 !o_recovered_positive_data && !o_recovered_negative_data)
    else $error("recovered outputs not muted during loss");
  AST_MON_FAIL: assert property (
    $rose(o_driver_failure_output) |->
    $past(silent_cnt_reg) == LCR_MON_SILENT_LIMIT - 8'h01)
    else $error("driver failure raised before silent limit");
  AST_MON_EXT: assert property (
    !tx_cfg_reg[LCR_TX_MON_BIT] && mon_state_reg == LCR_MON_WATCH &&
    (i_monitor_in_tip || i_monitor_in_ring) |=> silent_cnt_reg == 8'h00)
    else $error("external monitor pulse did not clear silence count");
  AST_RESET_ZERO: assert property (
    @(posedge i_clk) disable iff (1'b0)
    !i_rstn |=> tx_cfg_reg == LCR_TX_CFG_RESET &&
    rx_cfg_reg == LCR_RX_CFG_RESET)
    else $error("configuration not cleared by reset");

endmodule : lcr_line_ctrl
`default_nettype wire

// File: testbench/lcr_host_model.sv
// Host model that owns the parallel register strobe port
`timescale 1ns/1ps
`default_nettype none
module lcr_host_model
  import lcr_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Register port
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata,
  input wire logic i_rdata_valid
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and data are scrambled once released so stale values never help
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk);
    o_wr_en <= 1'b1;
    o_addr <= addr;
    o_wdata <= data;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_addr <= ~addr;
    o_wdata <= ~data;
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [7:0] data,
                    output logic ok);
    @(posedge i_clk);
    o_rd_en <= 1'b1;
    o_addr <= addr;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_addr <= ~addr;
    ok = 1'b0;
    data = 8'h00;
    // Valid is due at the first edge after the strobe was taken
    @(posedge i_clk);
    if (i_rdata_valid === 1'b1) begin
      ok = 1'b1;
      data = i_rdata;
    end
  endtask : rd
endmodule : lcr_host_model
`default_nettype wire

// File: testbench/test_tx_rx_line_control_regs.sv
// Self-checking bench for the line control register bank
`timescale 1ns/1ps
`default_nettype none
module test_tx_rx_line_control_regs import lcr_pkg::*;;
  logic clk = 1'b0, rstn = 1'b0, wr_en, rd_en, rvalid, prbs = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic tx_pin = 1'b0, tx_pos = 1'b0, tx_neg = 1'b0, tip, ring, bypass;
  logic err_ins, mon_tip = 1'b0, mon_ring = 1'b0, fail;
  logic rx_pin = 1'b0, rx_pos = 1'b0, rx_neg = 1'b0, aloss = 1'b0;
  logic dloss = 1'b0, rec_pos, rec_neg, eq_on, rx_mon, a_loss, d_loss;
  int err_count = 0;
  int checked = 0;

  always #10 clk = ~clk;

  lcr_host_model lcr_host_model_inst (.i_clk(clk), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata),
    .i_rdata_valid(rvalid));

  lcr_line_ctrl lcr_line_ctrl_inst (.i_clk(clk), .i_rstn(rstn),
    .i_reg_wr_en(wr_en), .i_reg_rd_en(rd_en), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rdata_valid(rvalid),
    .i_transmit_clock_pin(tx_pin), .i_transmit_positive_data(tx_pos),
    .i_transmit_negative_data(tx_neg), .i_prbs_enable(prbs),
    .o_line_out_tip(tip), .o_line_out_ring(ring),
    .o_build_out_bypass(bypass), .o_test_error_insert(err_ins),
    .i_monitor_in_tip(mon_tip), .i_monitor_in_ring(mon_ring),
    .o_driver_failure_output(fail), .i_recovered_clock_pin(rx_pin),
    .i_rx_positive_data(rx_pos), .i_rx_negative_data(rx_neg),
    .i_analog_loss_raw(aloss), .i_digital_loss_raw(dloss),
    .o_recovered_positive_data(rec_pos),
    .o_recovered_negative_data(rec_neg), .o_equalizer_on(eq_on),
    .o_receive_monitor_mode(rx_mon), .o_analog_signal_loss(a_loss),
    .o_digital_signal_loss(d_loss));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    lcr_host_model_inst.rd(a, d, ok);
    if (ok !== 1'b1) begin
      err_count++;
      $display("Error t=%0t read valid missing", $time);
      end_sim();
    end else begin
      chk(d, exp);
    end
  endtask : rd_chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Five cycles per level (an edge wait plus four) keeps each line clock level well above two cycles
  task automatic tx_edge(input logic lvl);
    @(posedge clk);
    tx_pin <= lvl;
    cyc(4);
  endtask : tx_edge

  // One full line bit: a rising then a falling transmit clock level change
  task automatic tx_bits(input int n);
    repeat (n) begin
      tx_edge(1'b1);
      tx_edge(1'b0);
    end
  endtask : tx_bits

  task automatic rx_edge(input logic lvl);
    @(posedge clk);
    rx_pin <= lvl;
    cyc(4);
  endtask : rx_edge

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(LCR_TX_CFG_ADDR, LCR_TX_CFG_RESET);
    rd_chk(LCR_RX_CFG_ADDR, LCR_RX_CFG_RESET);
    rd_chk(8'h07, LCR_UNMAPPED_READ);
  endtask : t_reset

  task automatic t_txcfg();
    lcr_host_model_inst.wr(LCR_TX_CFG_ADDR, 8'hFF);
    cyc(1);
    chk(bypass, 1'b1);
    chk(err_ins, 1'b0);
    rd_chk(LCR_TX_CFG_ADDR, 8'h27);
    lcr_host_model_inst.wr(LCR_TX_CFG_ADDR, 8'h00);
    cyc(1);
    chk(bypass, 1'b0);
  endtask : t_txcfg

  task automatic t_err();
    @(posedge clk);
    prbs <= 1'b1;
    lcr_host_model_inst.wr(LCR_TX_CFG_ADDR, 8'h10);
    cyc(1);
    chk(err_ins, 1'b1);
    cyc(1);
    chk(err_ins, 1'b0);
    prbs <= 1'b0;
    lcr_host_model_inst.wr(LCR_TX_CFG_ADDR, 8'h10);
    repeat (3) begin
      cyc(1);
      chk(err_ins, 1'b0);
    end
  endtask : t_err

  task automatic t_rxcfg();
    lcr_host_model_inst.wr(LCR_RX_CFG_ADDR, 8'h33);
    cyc(1);
    chk({eq_on, rx_mon}, 2'b11);
    rd_chk(LCR_RX_CFG_ADDR, 8'h33);
    aloss <= 1'b1;
    dloss <= 1'b1;
    cyc(3);
    chk({a_loss, d_loss}, 2'b00);
    lcr_host_model_inst.wr(LCR_RX_CFG_ADDR, 8'h00);
    cyc(2);
    chk({a_loss, d_loss, eq_on, rx_mon}, 4'b1100);
    aloss <= 1'b0;
    dloss <= 1'b0;
  endtask : t_rxcfg

  task automatic t_txedge();
    @(posedge clk);
    tx_pos <= 1'b1;
    tx_edge(1'b1);
    chk(tip, 1'b0);
    tx_edge(1'b0);
    chk({tip, ring}, 2'b10);
    lcr_host_model_inst.wr(LCR_TX_CFG_ADDR, 8'h02);
    tx_pos <= 1'b0;
    tx_neg <= 1'b1;
    tx_edge(1'b1);
    chk({tip, ring}, 2'b01);
    tx_pos <= 1'b1;
    tx_edge(1'b0);
    chk({tip, ring}, 2'b01);
    tx_neg <= 1'b0;
    lcr_host_model_inst.wr(LCR_TX_CFG_ADDR, 8'h00);
  endtask : t_txedge

  task automatic t_rxedge();
    @(posedge clk);
    rx_pos <= 1'b1;
    rx_neg <= 1'b1;
    rx_edge(1'b1);
    chk({rec_pos, rec_neg}, 2'b11);
    rx_pos <= 1'b0;
    rx_neg <= 1'b0;
    rx_edge(1'b0);
    chk({rec_pos, rec_neg}, 2'b11);
    lcr_host_model_inst.wr(LCR_RX_CFG_ADDR, 8'h08);
    rx_edge(1'b1);
    chk({rec_pos, rec_neg}, 2'b11);
    rx_edge(1'b0);
    chk({rec_pos, rec_neg}, 2'b00);
  endtask : t_rxedge

  task automatic t_mute();
    lcr_host_model_inst.wr(LCR_RX_CFG_ADDR, 8'h04);
    rx_pos <= 1'b1;
    rx_neg <= 1'b1;
    rx_edge(1'b1);
    chk({rec_pos, rec_neg}, 2'b11);
    aloss <= 1'b1;
    cyc(3);
    chk({rec_pos, rec_neg}, 2'b00);
    rx_edge(1'b0);
    rx_edge(1'b1);
    chk({rec_pos, rec_neg}, 2'b00);
    aloss <= 1'b0;
    rd_chk(LCR_RX_CFG_ADDR, 8'h04);
    rx_edge(1'b0);
    rx_edge(1'b1);
    chk({rec_pos, rec_neg}, 2'b11);
    lcr_host_model_inst.wr(LCR_RX_CFG_ADDR, 8'h00);
  endtask : t_mute

  task automatic t_mon();
    logic prev;
    logic nb;
    // A pulse clears the silence count so the limit is counted from zero
    mon_tip <= 1'b1;
    cyc(2);
    mon_tip <= 1'b0;
    tx_bits(127);
    chk(fail, 1'b0);
    tx_bits(1);
    chk(fail, 1'b1);
    mon_tip <= 1'b1;
    tx_bits(1);
    mon_tip <= 1'b0;
    cyc(2);
    chk(fail, 1'b0);
    lcr_host_model_inst.wr(LCR_TX_CFG_ADDR, 8'h24);
    tx_bits(1);
    prev = tip;
    repeat (130) begin
      tx_bits(1);
      nb = ~prev;
      chk({tip, ring}, {nb, prev});
      prev = tip;
    end
    chk(fail, 1'b0);
    // Data held low leaves the own driver silent, which must be flagged
    tx_pos <= 1'b0;
    lcr_host_model_inst.wr(LCR_TX_CFG_ADDR, 8'h20);
    tx_bits(130);
    chk(fail, 1'b1);
    lcr_host_model_inst.wr(LCR_TX_CFG_ADDR, 8'h00);
  endtask : t_mon

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(10);
    rstn <= 1'b1;
    t_reset();
    t_txcfg();
    t_err();
    t_rxcfg();
    t_txedge();
    t_rxedge();
    t_mute();
    t_mon();
    end_sim();
  end
endmodule : test_tx_rx_line_control_regs
`default_nettype wire
